// ===== hw/flow_ctl.sv
/*
 Program counter, banked carry/zero flags and six-level return stack of a
 small 8-bit core, reached by software over AXI4-Lite.
 Assumes one clock aclk and synchronous active-low reset aresetn.
*/
// Function
// - Program counter is twelve bits, addressing 4096 bytes directly.
// - Larger program space is reached through a separate page select register.
// - Counter increments after current instruction address is read out.
// - Relative branch adds signed offset to counter in the ALU path.
// - Counter loads jump, call, branch, vector, pop, or plus one.
// - Three carry/zero pairs: normal, interrupt, non-maskable.
// - Interrupt entry selects its pair; return from interrupt restores previous.
// - Flag pairs keep their values across context switches.
// - Only the active context's pair is readable or writable.
// - Carry set on arithmetic carry or borrow, else cleared.
// - Bit test copies bit into carry; rotate left goes through carry.
// - Zero flag set when latest arithmetic or logic result is zero.
// - After reset the non-maskable context is active.
// - Stack has six twelve-bit levels, LIFO, depth readable in the stack register.
// - Call or interrupt shifts levels deeper, counter plus one enters top.
// - Return loads top into counter and shifts deeper levels up.
// - Only the counter is stacked, no data registers.
// - Beyond six nested pushes stack saturates, oldest address lost.
// - Return on empty stack stays at top; next instruction follows.
// - CPU cycle is clock divided by 13; instructions take 2, 4 or 5.
// - Reset loads counter with reset vector at top of program memory.
`timescale 1ns/1ps
module flow_ctl #(
	parameter int DEPTH = flow_ctl_pkg::STACK_DEPTH,
	parameter int DIV   = flow_ctl_pkg::CLK_DIV
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [11:0]      prog_addr,
	output logic [7:0]       prog_page
);
	localparam logic [3:0] DIV_LAST = 4'(DIV - 1);

	// Bus handshake state
	logic        aw_ff, nxt_aw;
	logic        w_ff, nxt_w;
	logic [7:0]  awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0]  wstrb_ff, nxt_wstrb;
	logic        bvalid_ff, nxt_bvalid;
	logic [1:0]  bresp_ff, nxt_bresp;
	logic        rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0]  rresp_ff, nxt_rresp;
	// Core state
	logic [11:0] pc_ff, nxt_pc;
	logic [7:0]  page_ff, nxt_page;
	logic [31:0] operand_ff, nxt_operand;
	logic [11:0] stack_ff [DEPTH], nxt_stack [DEPTH];
	logic [2:0]  depth_ff, nxt_depth;
	logic        carry_normal_ctx_ff, nxt_carry_normal_ctx;
	logic        zero_normal_ctx_ff, nxt_zero_normal_ctx;
	logic        carry_irq_ctx_ff, nxt_carry_irq_ctx;
	logic        zero_irq_ctx_ff, nxt_zero_irq_ctx;
	logic        carry_nonmask_ctx_ff, nxt_carry_nonmask_ctx;
	logic        zero_nonmask_ctx_ff, nxt_zero_nonmask_ctx;
	flow_ctl_pkg::ctx_type ctx_ff, nxt_ctx;
	flow_ctl_pkg::ctx_type prev_ctx_ff, nxt_prev_ctx;
	flow_ctl_pkg::op_type  op_ff, nxt_op;
	logic        busy_ff, nxt_busy;
	logic [3:0]  div_ff, nxt_div;
	logic [2:0]  cyc_ff, nxt_cyc;

	// Merge a written word with byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// CPU cycles each command takes
	function automatic logic [2:0] op_cycles(input flow_ctl_pkg::op_type op);
		logic [2:0] c;
		c = flow_ctl_pkg::CYCLES_MID;
		unique case (op)
			flow_ctl_pkg::OP_NORMAL, flow_ctl_pkg::OP_LOGIC:
				c = flow_ctl_pkg::CYCLES_SHORT;
			flow_ctl_pkg::OP_CALL, flow_ctl_pkg::OP_IRQ, flow_ctl_pkg::OP_NMI,
			flow_ctl_pkg::OP_BITTEST:
				c = flow_ctl_pkg::CYCLES_LONG;
			default: c = flow_ctl_pkg::CYCLES_MID;
		endcase
		return c;
	endfunction

	logic        wr_fire;
	logic        cmd_write;
	logic        done;
	logic        act_c, act_z;
	logic [8:0]  alu_sum;
	logic [31:0] flags_word;
	logic        c_new, z_new, upd_c, upd_z;

	assign wr_fire = aw_ff && w_ff && !bvalid_ff;
	assign cmd_write = wr_fire && awaddr_ff == flow_ctl_pkg::ADDR_CMD && wstrb_ff[0];
	// Command completes at the last CPU cycle of its count
	assign done = busy_ff && div_ff == DIV_LAST && cyc_ff == 3'h1;
	// Only the active context pair is visible
	assign act_c = (ctx_ff == flow_ctl_pkg::CTX_NORMAL) ? carry_normal_ctx_ff :
		(ctx_ff == flow_ctl_pkg::CTX_IRQ) ? carry_irq_ctx_ff : carry_nonmask_ctx_ff;
	assign act_z = (ctx_ff == flow_ctl_pkg::CTX_NORMAL) ? zero_normal_ctx_ff :
		(ctx_ff == flow_ctl_pkg::CTX_IRQ) ? zero_irq_ctx_ff : zero_nonmask_ctx_ff;
	assign flags_word = {23'h0, busy_ff, 2'h0, ctx_ff, 2'h0, act_z, act_c};
	// Zero-extended result with no carry-in; operand supplies result and carry
	assign alu_sum = {1'b0, operand_ff[19:12]};

	// AXI4-Lite slave: address and data taken in any order, one at a time
	always_comb begin
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_awvalid && !aw_ff) begin
			nxt_aw = 1'b1;
			nxt_awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !w_ff) begin
			nxt_w = 1'b1;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_bvalid = 1'b1;
			unique case (awaddr_ff)
				flow_ctl_pkg::ADDR_CMD, flow_ctl_pkg::ADDR_OPERAND,
				flow_ctl_pkg::ADDR_PAGE, flow_ctl_pkg::ADDR_FLAGS:
					nxt_bresp = flow_ctl_pkg::RESP_OKAY;
				default: nxt_bresp = flow_ctl_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = flow_ctl_pkg::RESP_OKAY;
			unique case (s_axi_araddr[7:0])
				flow_ctl_pkg::ADDR_OPERAND: nxt_rdata = operand_ff;
				flow_ctl_pkg::ADDR_PAGE:    nxt_rdata = {24'h0, page_ff};
				flow_ctl_pkg::ADDR_PC:      nxt_rdata = {20'h0, pc_ff};
				flow_ctl_pkg::ADDR_FLAGS:   nxt_rdata = flags_word;
				flow_ctl_pkg::ADDR_STACK:   nxt_rdata = {17'h0, depth_ff, stack_ff[0]};
				flow_ctl_pkg::ADDR_CMD:     nxt_rdata = {28'h0, op_ff};
				default: begin
					nxt_rdata = 32'h0;
					nxt_rresp = flow_ctl_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= 2'h0;
		end else begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// Ready only while the slot is empty, so a held payload is taken once
	assign s_axi_awready = !aw_ff;
	assign s_axi_wready = !w_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign prog_addr = pc_ff;
	assign prog_page = page_ff;

	// Command sequencer and the flow state it updates at completion
	always_comb begin
		nxt_pc = pc_ff;
		nxt_page = page_ff;
		nxt_operand = operand_ff;
		nxt_stack = stack_ff;
		nxt_depth = depth_ff;
		nxt_carry_normal_ctx = carry_normal_ctx_ff;
		nxt_zero_normal_ctx = zero_normal_ctx_ff;
		nxt_carry_irq_ctx = carry_irq_ctx_ff;
		nxt_zero_irq_ctx = zero_irq_ctx_ff;
		nxt_carry_nonmask_ctx = carry_nonmask_ctx_ff;
		nxt_zero_nonmask_ctx = zero_nonmask_ctx_ff;
		nxt_ctx = ctx_ff;
		nxt_prev_ctx = prev_ctx_ff;
		nxt_op = op_ff;
		nxt_busy = busy_ff;
		nxt_div = div_ff;
		nxt_cyc = cyc_ff;
		// Flag results default to the active pair unchanged
		c_new = act_c;
		z_new = act_z;
		upd_c = 1'b0;
		upd_z = 1'b0;
		if (wr_fire && awaddr_ff == flow_ctl_pkg::ADDR_OPERAND) begin
			nxt_operand = merge(operand_ff, wdata_ff, wstrb_ff);
		end
		if (wr_fire && awaddr_ff == flow_ctl_pkg::ADDR_PAGE && wstrb_ff[0]) begin
			nxt_page = wdata_ff[7:0];
		end
		// Software writes only the active pair
		if (wr_fire && awaddr_ff == flow_ctl_pkg::ADDR_FLAGS && wstrb_ff[0]) begin
			unique case (ctx_ff)
				flow_ctl_pkg::CTX_NORMAL: begin
					nxt_carry_normal_ctx = wdata_ff[0];
					nxt_zero_normal_ctx = wdata_ff[1];
				end
				flow_ctl_pkg::CTX_IRQ: begin
					nxt_carry_irq_ctx = wdata_ff[0];
					nxt_zero_irq_ctx = wdata_ff[1];
				end
				default: begin
					nxt_carry_nonmask_ctx = wdata_ff[0];
					nxt_zero_nonmask_ctx = wdata_ff[1];
				end
			endcase
		end
		// A command written while busy is dropped; software polls busy first
		if (cmd_write && !busy_ff) begin
			nxt_op = flow_ctl_pkg::op_type'(wdata_ff[flow_ctl_pkg::CMD_LSB +: flow_ctl_pkg::CMD_W]);
			nxt_busy = 1'b1;
			nxt_div = 4'h0;
			nxt_cyc = op_cycles(flow_ctl_pkg::op_type'(wdata_ff[3:0]));
		end
		if (busy_ff) begin
			if (div_ff == DIV_LAST) begin
				nxt_div = 4'h0;
				nxt_cyc = cyc_ff - 3'h1;
			end else begin
				nxt_div = div_ff + 4'h1;
			end
		end
		if (done) begin
			nxt_busy = 1'b0;
			nxt_pc = pc_ff + 12'h001;
			unique case (op_ff)
				flow_ctl_pkg::OP_JUMP: nxt_pc = operand_ff[11:0];
				flow_ctl_pkg::OP_CALL, flow_ctl_pkg::OP_IRQ, flow_ctl_pkg::OP_NMI: begin
					// Only the return address goes on the stack
					nxt_stack[0] = pc_ff + 12'h001;
					for (int i = 1; i < DEPTH; i++) begin
						nxt_stack[i] = stack_ff[i-1];
					end
					if (depth_ff != 3'(DEPTH)) begin
						nxt_depth = depth_ff + 3'h1;
					end
					if (op_ff == flow_ctl_pkg::OP_CALL) begin
						nxt_pc = operand_ff[11:0];
					end else if (op_ff == flow_ctl_pkg::OP_IRQ) begin
						nxt_pc = flow_ctl_pkg::IRQ_VECTOR;
						nxt_prev_ctx = ctx_ff;
						nxt_ctx = flow_ctl_pkg::CTX_IRQ;
					end else begin
						nxt_pc = flow_ctl_pkg::NMI_VECTOR;
						nxt_prev_ctx = ctx_ff;
						nxt_ctx = flow_ctl_pkg::CTX_NONMASK;
					end
				end
				// Signed offset through the adder
				flow_ctl_pkg::OP_BRANCH: nxt_pc = pc_ff + operand_ff[11:0];
				flow_ctl_pkg::OP_RET, flow_ctl_pkg::OP_RETURN_FROM_INTERRUPT_INSTR: begin
					if (depth_ff != 3'h0) begin
						nxt_pc = stack_ff[0];
						for (int i = 0; i < DEPTH - 1; i++) begin
							nxt_stack[i] = stack_ff[i+1];
						end
						nxt_depth = depth_ff - 3'h1;
					end // else falls to next instruction
					if (op_ff == flow_ctl_pkg::OP_RETURN_FROM_INTERRUPT_INSTR) begin
						// Pairs keep their values; only selection moves
						nxt_ctx = prev_ctx_ff;
						nxt_prev_ctx = flow_ctl_pkg::CTX_NORMAL;
					end
				end
				flow_ctl_pkg::OP_ARITH: begin
					c_new = operand_ff[flow_ctl_pkg::OPD_CARRY];
					z_new = (alu_sum[7:0] == 8'h00);
					upd_c = 1'b1;
					upd_z = 1'b1;
				end
				flow_ctl_pkg::OP_LOGIC: begin
					z_new = (alu_sum[7:0] == 8'h00);
					upd_z = 1'b1;
				end
				flow_ctl_pkg::OP_BITTEST: begin
					c_new = operand_ff[flow_ctl_pkg::OPD_BIT];
					upd_c = 1'b1;
				end
				flow_ctl_pkg::OP_ROTL: begin
					// Carry takes bit 7; result gets old carry in bit 0
					c_new = operand_ff[flow_ctl_pkg::OPD_RES_LSB + 7];
					nxt_operand[19:12] = {operand_ff[18:12], act_c};
					z_new = ({operand_ff[18:12], act_c} == 8'h00);
					upd_c = 1'b1;
					upd_z = 1'b1;
				end
				default: nxt_pc = pc_ff + 12'h001;
			endcase
			// Flag results land in the pair of the current context
			if (upd_c || upd_z) begin
				unique case (ctx_ff)
					flow_ctl_pkg::CTX_NORMAL: begin
						if (upd_c) nxt_carry_normal_ctx = c_new;
						if (upd_z) nxt_zero_normal_ctx = z_new;
					end
					flow_ctl_pkg::CTX_IRQ: begin
						if (upd_c) nxt_carry_irq_ctx = c_new;
						if (upd_z) nxt_zero_irq_ctx = z_new;
					end
					default: begin
						if (upd_c) nxt_carry_nonmask_ctx = c_new;
						if (upd_z) nxt_zero_nonmask_ctx = z_new;
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_ff <= flow_ctl_pkg::PC_RESET;
			page_ff <= flow_ctl_pkg::PAGE_RESET;
			operand_ff <= 32'h0;
			for (int i = 0; i < DEPTH; i++) begin
				stack_ff[i] <= 12'h000;
			end
			depth_ff <= 3'h0;
			carry_normal_ctx_ff <= 1'b0;
			zero_normal_ctx_ff <= 1'b0;
			carry_irq_ctx_ff <= 1'b0;
			zero_irq_ctx_ff <= 1'b0;
			carry_nonmask_ctx_ff <= 1'b0;
			zero_nonmask_ctx_ff <= 1'b0;
			ctx_ff <= flow_ctl_pkg::CTX_NONMASK;
			prev_ctx_ff <= flow_ctl_pkg::CTX_NORMAL;
			op_ff <= flow_ctl_pkg::OP_NORMAL;
			busy_ff <= 1'b0;
			div_ff <= 4'h0;
			cyc_ff <= 3'h0;
		end else begin
			pc_ff <= nxt_pc;
			page_ff <= nxt_page;
			operand_ff <= nxt_operand;
			stack_ff <= nxt_stack;
			depth_ff <= nxt_depth;
			carry_normal_ctx_ff <= nxt_carry_normal_ctx;
			zero_normal_ctx_ff <= nxt_zero_normal_ctx;
			carry_irq_ctx_ff <= nxt_carry_irq_ctx;
			zero_irq_ctx_ff <= nxt_zero_irq_ctx;
			carry_nonmask_ctx_ff <= nxt_carry_nonmask_ctx;
			zero_nonmask_ctx_ff <= nxt_zero_nonmask_ctx;
			ctx_ff <= nxt_ctx;
			prev_ctx_ff <= nxt_prev_ctx;
			op_ff <= nxt_op;
			busy_ff <= nxt_busy;
			div_ff <= nxt_div;
			cyc_ff <= nxt_cyc;
		end
	end
endmodule

// ===== hw/flow_ctl_pkg.sv
/*
 Shared constants for the program flow control block: register offsets,
 field positions, reset values, vectors and cycle counts.
 Assumes a single 10 MHz bus clock and an AXI4-Lite register bus.
*/
package flow_ctl_pkg;
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 6;
	localparam int CLK_DIV = 13;
	localparam logic [11:0] RESET_VECTOR = 12'hFFE;
	localparam logic [11:0] NMI_VECTOR = 12'hFFC;
	localparam logic [11:0] IRQ_VECTOR = 12'hFF0;
	localparam logic [11:0] PC_RESET = 12'hFFE;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	// Register byte addresses
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_PAGE = 8'h08;
	localparam logic [7:0] ADDR_PC = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_STACK = 8'h14;
	// Command field in the command register
	localparam int CMD_LSB = 0;
	localparam int CMD_W = 4;
	// Operand layout: target/offset in [11:0], ALU result in [19:12],
	// bit-test value [21], carry out of ALU [22]
	localparam int OPD_RES_LSB = 12;
	localparam int OPD_CARRY = 22;
	localparam int OPD_BIT = 21;
	// Status layout in the flags register
	localparam int FLG_CTX_LSB = 4;
	localparam int FLG_BUSY = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [2:0] CYCLES_SHORT = 3'h2;
	localparam logic [2:0] CYCLES_MID = 3'h4;
	localparam logic [2:0] CYCLES_LONG = 3'h5;
	typedef enum logic [3:0] {
		OP_NORMAL, OP_JUMP, OP_CALL, OP_BRANCH, OP_IRQ, OP_NMI,
		OP_RET, OP_RETURN_FROM_INTERRUPT_INSTR, OP_ARITH, OP_LOGIC, OP_BITTEST, OP_ROTL
	} op_type;
	typedef enum logic [1:0] { CTX_NORMAL, CTX_IRQ, CTX_NONMASK } ctx_type;
endpackage

// ===== tb/flow_ctl_assertions.sv
/* Port checker for flow_ctl: reset values, register reads, page and PC update.
 Assumes it is bound onto flow_ctl and sees only the ports of that module. */
`timescale 1ns/1ps
module flow_ctl_assertions #(
	parameter int DEPTH = 6,
	parameter int DIV   = 13
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [11:0] prog_addr,
	input wire logic [7:0]  prog_page
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       wr_both, pg_wr, cmd_wr, rd_go;
	logic [7:0] pg_d_ff, nxt_pg_d, since_ff, nxt_since;
	// Writes only count when address and data meet on one edge, as the bench sends them
	assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign pg_wr = wr_both && s_axi_awaddr[7:0] == 8'h08 && s_axi_wstrb[0];
	assign cmd_wr = wr_both && s_axi_awaddr[7:0] == 8'h00;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	// Last page byte written, and cycles since the last command (saturating)
	always_comb begin
		nxt_pg_d = pg_wr ? s_axi_wdata[7:0] : pg_d_ff;
		nxt_since = cmd_wr ? 8'h00 : (since_ff == 8'hFF ? since_ff : since_ff + 8'h01);
	end
	always_ff @(posedge aclk) begin
		pg_d_ff <= nxt_pg_d;
		since_ff <= aresetn ? nxt_since : 8'hFF;
	end
	AST_RST_PC: assert property (disable iff (1'b0) !aresetn |=> prog_addr == 12'hFFE)
		else $error("pc not at reset vector");
	AST_RST_PAGE: assert property (disable iff (1'b0) !aresetn |=> prog_page == 8'h00)
		else $error("page not cleared by reset");
	AST_PAGE_WR: assert property (pg_wr |=> ##[0:2] prog_page == pg_d_ff)
		else $error("page output missed the written byte");
	AST_PC_RD: assert property (rd_go && s_axi_araddr[7:0] == 8'h0C |=>
		s_axi_rvalid && s_axi_rdata == {20'h0, $past(prog_addr)})
		else $error("pc read differs from pc output");
	AST_STK_DEPTH: assert property (rd_go && s_axi_araddr[7:0] == 8'h14 |=>
		s_axi_rdata[31:15] == 17'h0 && s_axi_rdata[14:12] <= 3'h6)
		else $error("stack depth above six");
	// A reset moves the pc with no command, so the edge right after reset is skipped
	AST_PC_WINDOW: assert property ($past(aresetn) && $changed(prog_addr) |->
		since_ff <= 5 * DIV + 4)
		else $error("pc moved outside a command");
	AST_UNMAP_RD: assert property (rd_go && s_axi_araddr[7:0] == 8'h18 |=>
		s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_UNMAP_WR: assert property (wr_both && s_axi_awaddr[7:0] == 8'h18 |->
		##[1:3] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("unmapped write not refused");
	AST_AR_BLOCK: assert property (rd_go |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing after address taken");
	// Main scenarios
	cover property (cmd_wr);
	cover property (pg_wr);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (rd_go && s_axi_araddr[7:0] == 8'h14);
endmodule
bind flow_ctl flow_ctl_assertions #(.DEPTH(DEPTH), .DIV(DIV)) u_chk (.*);

// ===== tb/alu_model.sv
/* Behavioural ALU standing in for the core's arithmetic unit.
 Assumes the bench hands its word to the operand register unchanged. */
`timescale 1ns/1ps
module alu_model (
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        sub,
	output logic      [31:0] word
);
	logic [8:0] sum;
	// Ninth bit is the carry on add and the borrow on subtract
	assign sum = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
	// Carry to bit 22, result to bits 19:12
	assign word = {9'h0, sum[8], 2'h0, sum[7:0], 12'h0};
endmodule

// ===== tb/flow_ctl_tb.sv
/* Self-checking bench for flow_ctl: AXI4-Lite tasks plus a reference model of pc and stack.
 Assumes the checker is bound in and DIV is shrunk to keep runs short. */
`timescale 1ns/1ps
module flow_ctl_tb;
	localparam int DIV = 2;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd_d, alu_word;
	logic [11:0] prog_addr, pc = 12'hFFE;
	logic [7:0]  prog_page, alu_a = 8'h00, alu_b = 8'h00;
	logic        alu_sub = 1'b0;
	logic [1:0]  ctx = 2'h2, sctx = 2'h0;
	logic [11:0] stk[$];
	int          errors = 0, n_compared = 0;
	always #50 aclk = ~aclk;
	flow_ctl #(.DIV(DIV)) i_dut (.*);
	alu_model i_alu (.a(alu_a), .b(alu_b), .sub(alu_sub), .word(alu_word));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ready lines stay high, so each response is taken on the edge it is seen.
	// Waits have no limit of their own: only the watchdog ends a hung transfer.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_d = s_axi_rdata;
		if (m != 32'h0) chk(rd_d & m, e);
	endtask
	// Issue one command, wait for busy to drop, then compare pc, stack and context
	task automatic cmd(input logic [3:0] op, input logic [31:0] opd);
		wr(8'h04, opd, 2'h0);
		wr(8'h00, {28'h0, op}, 2'h0);
		do begin
			rd(8'h10, 32'h0, 32'h0);
		end while (rd_d[8] !== 1'b0);
		case (op)
			4'h1: pc = opd[11:0];
			4'h2, 4'h4, 4'h5: begin
				stk.push_front(pc + 12'h1);
				if (stk.size() > 6) void'(stk.pop_back());
				pc = (op == 4'h2) ? opd[11:0] : (op == 4'h4) ? 12'hFF0 : 12'hFFC;
				if (op != 4'h2) sctx = ctx;
				if (op != 4'h2) ctx = (op == 4'h4) ? 2'h1 : 2'h2;
			end
			4'h3: pc = pc + opd[11:0];
			4'h6, 4'h7: begin
				pc = (stk.size() > 0) ? stk.pop_front() : pc + 12'h1;
				if (op == 4'h7) ctx = sctx;
			end
			default: pc = pc + 12'h1;
		endcase
		chk({20'h0, prog_addr}, {20'h0, pc});
		rd(8'h14, 32'h7000, stk.size() << 12);
		if (stk.size() > 0) rd(8'h14, 32'hFFF, {20'h0, stk[0]});
		rd(8'h10, 32'h30, {26'h0, ctx, 4'h0});
	endtask
	task automatic alu(input logic [7:0] a, input logic [7:0] b, input logic s);
		alu_a = a;
		alu_b = b;
		alu_sub = s;
		@(posedge aclk);
		cmd(4'd8, alu_word);
	endtask
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Run needs under two thousand cycles; this bound is far beyond that
	initial begin
		#1000000;
		errors++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({20'h0, prog_addr}, 32'hFFE);
		rd(8'h10, 32'h33, 32'h20);
		wr(8'h08, 32'h5A, 2'h0);
		rd(8'h08, 32'hFF, 32'h5A);
		chk({24'h0, prog_page}, 32'h5A);
		wr(8'h10, 32'h3, 2'h0);
		cmd(4'h7, 32'h0);
		rd(8'h10, 32'h3, 32'h0);
		cmd(4'h0, 32'h0);
		cmd(4'h1, 32'h100);
		cmd(4'h3, 32'hFFE);
		cmd(4'h3, 32'h005);
		cmd(4'h9, 32'h0);
		rd(8'h10, 32'h2, 32'h2);
		alu(8'hF0, 8'h10, 1'b0);
		rd(8'h10, 32'h3, 32'h3);
		alu(8'h05, 8'h07, 1'b1);
		rd(8'h10, 32'h3, 32'h1);
		alu(8'h12, 8'h34, 1'b0);
		rd(8'h10, 32'h3, 32'h0);
		cmd(4'h4, 32'h0);
		rd(8'h10, 32'h3, 32'h0);
		wr(8'h10, 32'h1, 2'h0);
		cmd(4'h5, 32'h0);
		rd(8'h10, 32'h3, 32'h3);
		cmd(4'h7, 32'h0);
		rd(8'h10, 32'h3, 32'h1);
		cmd(4'h6, 32'h0);
		for (int i = 0; i < 7; i++) cmd(4'h2, 32'h200 + 32'(16 * i));
		rd(8'h0C, 32'hFFFFFFFF, {20'h0, pc});
		for (int i = 0; i < 7; i++) cmd(4'h6, 32'h0);
		cmd(4'hA, 32'h0020_0000);
		rd(8'h10, 32'h1, 32'h1);
		cmd(4'hB, 32'h0008_0000);
		rd(8'h10, 32'h3, 32'h1);
		rd(8'h04, 32'h000F_F000, 32'h0000_1000);
		// Mid-run reset with a full stack history: everything returns to start values
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		pc = 12'hFFE;
		ctx = 2'h2;
		sctx = 2'h0;
		stk.delete();
		@(posedge aclk);
		chk({20'h0, prog_addr}, 32'hFFE);
		chk({24'h0, prog_page}, 32'h0);
		rd(8'h14, 32'h7000, 32'h0);
		rd(8'h10, 32'h33, 32'h20);
		wr(8'h18, 32'h1, 2'h2);
		rd(8'h18, 32'hFFFFFFFF, 32'h0);
		test_done();
	end
endmodule
